// >>> inc/msdr_pkg.sv
package msdr_pkg;

	localparam int CLK_MHZ = 50;
	localparam int STRETCH_LIMIT_US = 1000;
	localparam int STRETCH_MAX_CYC = STRETCH_LIMIT_US * CLK_MHZ;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	localparam logic [7:0] CMD_CLASS = 8'h01;
	localparam logic [7:0] CMD_CHANNELS = 8'h02;
	localparam logic [7:0] CMD_PLUG = 8'h03;
	localparam logic [7:0] CMD_RATE = 8'h04;
	localparam logic [7:0] CMD_REACH = 8'h05;
	localparam logic [7:0] CMD_MAKER = 8'h06;
	localparam logic [7:0] CMD_PART = 8'h07;
	localparam logic [7:0] CMD_RELEASE = 8'h08;
	localparam logic [7:0] CMD_WAVE = 8'h09;
	localparam logic [7:0] CMD_UNIT = 8'h0A;
	localparam logic [7:0] CMD_DAY = 8'h0B;
	localparam logic [7:0] CMD_FEATURE = 8'h0C;

	localparam logic [7:0] STS_OK = 8'h00;
	localparam logic [7:0] STS_UNKNOWN = 8'h01;
	localparam logic [7:0] STS_CHECK_ERR = 8'h05;
	localparam logic [7:0] STS_NOT_EXEC = 8'h09;

	localparam int STATIC_BYTES = 49;
	localparam logic [5:0] OFS_CLASS = 6'h00;
	localparam logic [5:0] OFS_CHANNELS = 6'h01;
	localparam logic [5:0] OFS_PLUG = 6'h02;
	localparam logic [5:0] OFS_RATE = 6'h03;
	localparam logic [5:0] OFS_REACH = 6'h04;
	localparam logic [5:0] OFS_MAKER = 6'h05;
	localparam logic [5:0] OFS_PART = 6'h06;
	localparam logic [5:0] OFS_RELEASE = 6'h16;
	localparam logic [5:0] OFS_WAVE = 6'h18;
	localparam logic [5:0] OFS_UNIT = 6'h1C;
	localparam logic [5:0] OFS_DAY = 6'h2C;
	localparam logic [5:0] OFS_FEATURE = 6'h30;
	localparam logic [4:0] LEN_ONE = 5'h01;
	localparam logic [4:0] LEN_TWO = 5'h02;
	localparam logic [4:0] LEN_FOUR = 5'h04;
	localparam logic [4:0] LEN_STRING = 5'h10;
	localparam logic [7:0] FEATURE_MASK = 8'h1F;

	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STRETCH = 12'h004;
	localparam logic [11:0] A_PREP = 12'h008;
	localparam logic [11:0] A_STATUS = 12'h00C;
	localparam logic [11:0] A_STATIC = 12'h100;
	localparam logic [11:0] A_STATIC_END = 12'h1C4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		B_IDLE = 3'b000,
		B_RX = 3'b001,
		B_ACK = 3'b010,
		B_TX = 3'b011,
		B_TXACK = 3'b100
	} link_state_t;

	typedef struct packed {
		logic valid;
		logic [5:0] ofs;
		logic [4:0] len;
	} query_t;

	typedef struct packed {
		logic [7:0] unused;
		logic [7:0] last_status;
		logic [7:0] last_cmd;
		logic [5:0] zero;
		logic link_busy;
		logic pending;
	} status_word_t;

	typedef struct packed {
		logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
		link_state_t link;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic is_addr, rw, mack;
		logic [1:0] rx_idx;
		logic [4:0] tx_idx;
		logic [7:0] cmd_rx, check_rx, xor_acc, reply_cmd, reply_status;
		logic pending;
		logic [15:0] prep_cnt, stretch_cnt;
		logic scl_oe_n, sda_oe_n, line_low;
		logic rt_busy;
		logic [15:0] stretch_len, prep_len;
		logic [STATIC_BYTES-1:0][7:0] store;
		logic awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [11:0] aw_addr;
		logic [31:0] wdata, rdata;
		logic [3:0] wstrb;
	} state_t;

	function automatic state_t reset_state();
		state_t s;
		s = '0;
		s.scl_s1 = 1'b1;
		s.scl_s2 = 1'b1;
		s.scl_d = 1'b1;
		s.sda_s1 = 1'b1;
		s.sda_s2 = 1'b1;
		s.sda_d = 1'b1;
		s.scl_oe_n = 1'b1;
		s.sda_oe_n = 1'b1;
		s.reply_status = STS_NOT_EXEC;
		s.awready = 1'b1;
		s.wready = 1'b1;
		s.arready = 1'b1;
		return s;
	endfunction

endpackage

// >>> rtl/module_static_data_responder.sv
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Operation
// (RQ1) module may hold serial clock low after address, received bytes, before sent bytes
// (RQ2) any single clock stretch lasts at most 1ms
// (RQ3) write address refused while a real-time task runs
// (RQ4) read address refused while a real-time task runs
// (RQ5) read address refused while the previous reply is still being prepared
// (RQ6) after a refusal the master stops and waits 10ms before retrying
// (RQ7) command byte equals listed query code; static queries use read-back frames
// (RQ8) code 01h returns one transceiver category byte
// (RQ9) code 02h returns one byte counting wavelength channels, 1 means fixed
// (RQ10) code 03h returns one connector code byte
// (RQ11) code 04h returns one byte of nominal rate in 100Mbps units
// (RQ12) code 05h returns one binary byte of reach in 10km units
// (RQ13) code 06h returns one maker code byte
// (RQ14) code 07h returns 16 ASCII part bytes, leading character first
// (RQ15) code 08h returns two BCD revision bytes, minor byte first
// (RQ16) code 09h returns four BCD wavelength bytes, least significant first
// (RQ17) code 0Ah returns 16 ASCII serial bytes, leading character first
// (RQ18) code 0Bh returns four BCD date bytes: day, month, year, century
// (RQ19) code 0Ch returns feature bits 4..0, bits 7..5 reserved zero
// (RQ20) reply byte counts exclude status and check byte
// (RQ21) codes 0Dh to 10h are not defined queries
// (RQ22) unsupported code reports status 01h and skips checksum verification
// (RQ23) reply check byte is XOR of read address, status and data bytes
// (RQ24) reserved codes answer like unsupported: status and check byte only
module module_static_data_responder
	import msdr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h50,
	parameter int STRETCH_MAX = STRETCH_MAX_CYC
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n
);

	localparam logic [15:0] STRETCH_CAP = 16'(STRETCH_MAX);

	state_t st_r;
	state_t st_nxt;

	logic scl_rise, scl_fall, start_cond, stop_cond;
	query_t rq, wq;
	logic [4:0] reply_len;
	logic [7:0] tx_byte;
	logic tx_more;
	logic [15:0] stretch_eff;

	// every query code maps to its place in the static store
	function automatic query_t query_info(input logic [7:0] code);
		query_t q;
		q = '0;
		q.valid = 1'b1;
		unique case (code) // RQ7
			CMD_CLASS: begin // RQ8
				q.ofs = OFS_CLASS;
				q.len = LEN_ONE;
			end
			CMD_CHANNELS: begin // RQ9
				q.ofs = OFS_CHANNELS;
				q.len = LEN_ONE;
			end
			CMD_PLUG: begin // RQ10
				q.ofs = OFS_PLUG;
				q.len = LEN_ONE;
			end
			CMD_RATE: begin // RQ11
				q.ofs = OFS_RATE;
				q.len = LEN_ONE;
			end
			CMD_REACH: begin // RQ12
				q.ofs = OFS_REACH;
				q.len = LEN_ONE;
			end
			CMD_MAKER: begin // RQ13
				q.ofs = OFS_MAKER;
				q.len = LEN_ONE;
			end
			CMD_PART: begin // RQ14
				q.ofs = OFS_PART;
				q.len = LEN_STRING;
			end
			CMD_RELEASE: begin // RQ15
				q.ofs = OFS_RELEASE;
				q.len = LEN_TWO;
			end
			CMD_WAVE: begin // RQ16
				q.ofs = OFS_WAVE;
				q.len = LEN_FOUR;
			end
			CMD_UNIT: begin // RQ17
				q.ofs = OFS_UNIT;
				q.len = LEN_STRING;
			end
			CMD_DAY: begin // RQ18
				q.ofs = OFS_DAY;
				q.len = LEN_FOUR;
			end
			CMD_FEATURE: begin // RQ19
				q.ofs = OFS_FEATURE;
				q.len = LEN_ONE;
			end
			default: q.valid = 1'b0; // RQ21
		endcase
		return q;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [15:0] m;
		m = old;
		if (be[0]) m[7:0] = d[7:0];
		if (be[1]) m[15:8] = d[15:8];
		return m;
	endfunction

	function automatic logic in_store(input logic [11:0] a);
		return (a >= A_STATIC) && (a < A_STATIC_END) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [5:0] store_idx(input logic [11:0] a);
		return 6'((a - A_STATIC) >> 2);
	endfunction

	// the first flops feed only the second ones; edges use the settled copies
	assign scl_rise = st_r.scl_s2 & ~st_r.scl_d;
	assign scl_fall = ~st_r.scl_s2 & st_r.scl_d;
	assign start_cond = st_r.scl_s2 & st_r.scl_d & ~st_r.sda_s2 & st_r.sda_d;
	assign stop_cond = st_r.scl_s2 & st_r.scl_d & st_r.sda_s2 & ~st_r.sda_d;

	assign rq = query_info(st_r.reply_cmd);
	assign wq = query_info(st_r.cmd_rx);
	// data follows the status only when the command ran
	assign reply_len = (st_r.reply_status == STS_OK) ? rq.len : 5'h00; // RQ20 RQ24
	assign tx_byte = (st_r.tx_idx == 5'h00) ? st_r.reply_status :
		(st_r.tx_idx <= reply_len) ? st_r.store[rq.ofs + 6'(st_r.tx_idx) - 6'h01] :
		st_r.xor_acc; // RQ23
	assign tx_more = st_r.tx_idx <= reply_len + 5'h01;
	assign stretch_eff = (st_r.stretch_len > STRETCH_CAP) ? STRETCH_CAP : st_r.stretch_len; // RQ2

	always_comb begin
		logic load;
		logic strt;
		load = 1'b0;
		strt = 1'b0;
		st_nxt = st_r;
		st_nxt.scl_s1 = scl_i;
		st_nxt.scl_s2 = st_r.scl_s1;
		st_nxt.scl_d = st_r.scl_s2;
		st_nxt.sda_s1 = sda_i;
		st_nxt.sda_s2 = st_r.sda_s1;
		st_nxt.sda_d = st_r.sda_s2;

		if (st_r.pending) begin
			if (st_r.prep_cnt == 16'h0000) st_nxt.pending = 1'b0;
			else st_nxt.prep_cnt = st_r.prep_cnt - 16'h0001;
		end
		if (st_r.stretch_cnt != 16'h0000) st_nxt.stretch_cnt = st_r.stretch_cnt - 16'h0001;
		else st_nxt.scl_oe_n = 1'b1;

		unique case (st_r.link)
			B_IDLE: begin
			end
			B_RX: begin
				if (scl_rise) begin
					st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_s2};
					st_nxt.bitcnt = st_r.bitcnt + 4'h1;
				end
				if (scl_fall && st_r.bitcnt == BITS_PER_BYTE) begin
					st_nxt.bitcnt = 4'h0;
					st_nxt.link = B_ACK;
					st_nxt.sda_oe_n = 1'b0;
					if (st_r.is_addr) begin
						st_nxt.is_addr = 1'b0;
						st_nxt.rw = st_r.shreg[0];
						st_nxt.xor_acc = st_r.shreg;
						st_nxt.tx_idx = 5'h00;
						// a refusal is just a released line on the ninth clock
						if (st_r.shreg[7:1] != DEV_ADDR) begin
							st_nxt.link = B_IDLE;
							st_nxt.sda_oe_n = 1'b1;
						end else if (!st_r.shreg[0] && st_r.rt_busy) begin // RQ3
							st_nxt.link = B_IDLE;
							st_nxt.sda_oe_n = 1'b1;
						end else if (st_r.shreg[0] && (st_r.rt_busy || st_r.pending)) begin // RQ4 RQ5
							st_nxt.link = B_IDLE;
							st_nxt.sda_oe_n = 1'b1;
						end
					end else begin
						if (st_r.rx_idx == 2'h0) begin
							st_nxt.cmd_rx = st_r.shreg;
							st_nxt.xor_acc = st_r.xor_acc ^ st_r.shreg;
						end
						if (st_r.rx_idx == 2'h1) st_nxt.check_rx = st_r.shreg;
						if (st_r.rx_idx != 2'h2) st_nxt.rx_idx = st_r.rx_idx + 2'h1;
					end
				end
			end
			B_ACK: begin
				if (scl_fall) begin
					strt = 1'b1;
					st_nxt.sda_oe_n = 1'b1;
					st_nxt.link = B_RX;
					if (st_r.rw) load = 1'b1;
				end
			end
			B_TX: begin
				if (scl_fall) begin
					if (st_r.bitcnt == BITS_PER_BYTE) begin
						st_nxt.link = B_TXACK;
						st_nxt.sda_oe_n = 1'b1;
					end else begin
						st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
						st_nxt.sda_oe_n = st_r.shreg[6];
						st_nxt.bitcnt = st_r.bitcnt + 4'h1;
					end
				end
			end
			B_TXACK: begin
				if (scl_rise) st_nxt.mack = st_r.sda_s2;
				if (scl_fall) begin
					if (!st_r.mack && tx_more) begin
						load = 1'b1;
						strt = 1'b1;
					end else begin
						st_nxt.link = B_IDLE;
					end
				end
			end
			default: st_nxt.link = B_IDLE;
		endcase

		if (load) begin
			st_nxt.link = B_TX;
			st_nxt.shreg = tx_byte;
			st_nxt.sda_oe_n = tx_byte[7];
			st_nxt.bitcnt = 4'h1;
			st_nxt.tx_idx = st_r.tx_idx + 5'h01;
			st_nxt.xor_acc = st_r.xor_acc ^ tx_byte; // RQ23
		end
		// hold the clock low right after the acknowledge bit while data gets ready
		if (strt && stretch_eff != 16'h0000) begin // RQ1
			st_nxt.scl_oe_n = 1'b0;
			st_nxt.stretch_cnt = stretch_eff - 16'h0001; // RQ2
		end

		if (start_cond) begin
			st_nxt.link = B_RX;
			st_nxt.is_addr = 1'b1;
			st_nxt.bitcnt = 4'h0;
			st_nxt.rx_idx = 2'h0;
			st_nxt.sda_oe_n = 1'b1;
		end
		if (stop_cond) begin
			st_nxt.link = B_IDLE;
			st_nxt.sda_oe_n = 1'b1;
			st_nxt.rx_idx = 2'h0;
			// only a write frame with command and check byte makes a new reply
			if (st_r.rx_idx == 2'h2) begin
				st_nxt.reply_cmd = st_r.cmd_rx;
				st_nxt.pending = 1'b1;
				st_nxt.prep_cnt = st_r.prep_len;
				if (!wq.valid) st_nxt.reply_status = STS_UNKNOWN; // RQ22 RQ24
				else if (st_r.xor_acc != st_r.check_rx) st_nxt.reply_status = STS_CHECK_ERR;
				else st_nxt.reply_status = STS_OK;
			end
		end

		if (awvalid && st_r.awready) begin
			st_nxt.awready = 1'b0;
			st_nxt.aw_addr = awaddr;
		end
		if (wvalid && st_r.wready) begin
			st_nxt.wready = 1'b0;
			st_nxt.wdata = wdata;
			st_nxt.wstrb = wstrb;
		end
		if (!st_r.awready && !st_r.wready && !st_r.bvalid) begin
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case (st_r.aw_addr)
				A_CTRL: if (st_r.wstrb[0]) st_nxt.rt_busy = st_r.wdata[0];
				A_STRETCH: st_nxt.stretch_len = merge16(st_r.stretch_len, st_r.wdata, st_r.wstrb);
				A_PREP: st_nxt.prep_len = merge16(st_r.prep_len, st_r.wdata, st_r.wstrb);
				A_STATUS: begin
				end
				default: begin
					if (!in_store(st_r.aw_addr)) st_nxt.bresp = RESP_SLVERR;
					else if (st_r.wstrb[0]) begin
						if (store_idx(st_r.aw_addr) == OFS_FEATURE)
							st_nxt.store[OFS_FEATURE] = st_r.wdata[7:0] & FEATURE_MASK; // RQ19
						else
							st_nxt.store[store_idx(st_r.aw_addr)] = st_r.wdata[7:0];
					end
				end
			endcase
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready = 1'b1;
		end

		if (arvalid && st_r.arready) begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			case (araddr)
				A_CTRL: st_nxt.rdata[0] = st_r.rt_busy;
				A_STRETCH: st_nxt.rdata[15:0] = st_r.stretch_len;
				A_PREP: st_nxt.rdata[15:0] = st_r.prep_len;
				A_STATUS: st_nxt.rdata = status_word_t'{
					unused: 8'h00,
					last_status: st_r.reply_status,
					last_cmd: st_r.reply_cmd,
					zero: 6'h00,
					link_busy: st_r.link != B_IDLE,
					pending: st_r.pending};
				default: begin
					if (in_store(araddr)) st_nxt.rdata[7:0] = st_r.store[store_idx(araddr)];
					else st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) st_r <= reset_state();
		else st_r <= st_nxt;
	end

	assign awready = st_r.awready;
	assign wready = st_r.wready;
	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign arready = st_r.arready;
	assign rvalid = st_r.rvalid;
	assign rdata = st_r.rdata;
	assign rresp = st_r.rresp;
	// both lines are open drain: only ever pulled low
	assign scl_o = st_r.line_low;
	assign sda_o = st_r.line_low;
	assign scl_oe_n = st_r.scl_oe_n;
	assign sda_oe_n = st_r.sda_oe_n;

endmodule

// >>> sim/msdr_monitor.sv
`timescale 1ns/1ps
module msdr_monitor
	import msdr_pkg::*;
#(
	parameter int STRETCH_MAX = STRETCH_MAX_CYC
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_n,
	input wire logic sda_o,
	input wire logic sda_oe_n
);
	logic [15:0] low_cnt;
	// a counter, not a repetition: the limit is tens of thousands of cycles
	always_ff @(posedge aclk) begin
		if (!aresetn)
			low_cnt <= 16'h0000;
		else
			low_cnt <= scl_oe_n ? 16'h0000 : low_cnt + 16'h0001;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_stretch_max: assert property (!scl_oe_n |-> low_cnt < STRETCH_MAX)
		else $error("clock held low too long");
	a_stretch_low: assert property ($fell(scl_oe_n) |-> !$past(scl_i))
		else $error("stretch began on a high clock");
	a_data_low: assert property ($changed(sda_oe_n) |-> !$past(scl_i))
		else $error("data line moved while clock high");
	a_drain_only: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("open drain pin driven high");
	a_wr_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
		else $error("write response not two cycles after handshake");
	a_wr_close: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write channel not reopened");
	a_rd_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	a_rd_close: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read channel not reopened");
	a_err_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h00000000)
		else $error("refused read carried data");
	c_stretch_full: cover property (low_cnt == STRETCH_MAX - 1);
	c_refused: cover property (rvalid && rresp == RESP_SLVERR);
	c_ack: cover property ($fell(sda_oe_n));
endmodule
bind module_static_data_responder msdr_monitor #(.STRETCH_MAX(STRETCH_MAX)) mon (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
	.scl_i, .scl_o, .scl_oe_n, .sda_o, .sda_oe_n
);

// >>> sim/msdr_host_model.sv
`timescale 1ns/1ps
module msdr_host_model #(
	parameter logic [6:0] ADDR = 7'h50,
	parameter int RETRY_CYC = 500000
)(
	input wire logic aclk,
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	output logic scl_i,
	output logic sda_i
);
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	logic [7:0] rx [0:17];
	// both lines are pulled up, so a released line reads high
	assign scl_i = m_scl & scl_oe_n;
	assign sda_i = m_sda & sda_oe_n;
	task automatic hold(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic rise();
		m_scl <= 1'b1;
		do @(posedge aclk); while (scl_i !== 1'b1);
	endtask
	task automatic clk_bit(input logic b, output logic r);
		m_sda <= b;
		hold(4);
		rise();
		hold(3);
		r = sda_i;
		m_scl <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic nak);
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], q[i]);
		clk_bit(last, nak);
	endtask
	task automatic start();
		m_sda <= 1'b0;
		hold(4);
		m_scl <= 1'b0;
	endtask
	task automatic stop(input logic nak);
		m_sda <= 1'b0;
		hold(4);
		rise();
		hold(4);
		m_sda <= 1'b1;
		hold(4);
		if (nak)
			hold(RETRY_CYC);
	endtask
	task automatic send_cmd(input logic [7:0] code, input logic [7:0] check, output logic nak);
		logic [7:0] q;
		logic n2;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, nak);
		if (!nak) begin
			xfer(code, 1'b1, q, n2);
			xfer(check, 1'b1, q, n2);
		end
		stop(nak);
	endtask
	task automatic get_reply(input int n, output logic nak);
		logic [7:0] q;
		logic a;
		start();
		xfer({ADDR, 1'b1}, 1'b1, q, nak);
		for (int i = 0; i < n && !nak; i++)
			xfer(8'hFF, i == n - 1, rx[i], a);
		stop(nak);
	endtask
endmodule

// >>> sim/module_static_data_responder_tb_top.sv
`timescale 1ns/1ps
module module_static_data_responder_tb_top;
	import msdr_pkg::*;
	localparam logic [6:0] DEV = 7'h50;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe_n, sda_o, sda_oe_n;
	logic [11:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic scl_i, sda_i;
	int fails, check_count;
	int lens [1:12] = '{1, 1, 1, 1, 1, 1, 16, 2, 4, 16, 4, 1};
	module_static_data_responder #(.DEV_ADDR(DEV), .STRETCH_MAX(40)) dut (
		.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .scl_i, .scl_o, .scl_oe_n,
		.sda_i, .sda_o, .sda_oe_n
	);
	// back-off kept short here so the run stays brief; it still outlasts the reply wait
	msdr_host_model #(.ADDR(DEV), .RETRY_CYC(4000)) host (
		.aclk, .scl_oe_n, .sda_oe_n, .scl_i, .sda_i
	);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_ready();
		logic [31:0] d;
		logic [1:0] r;
		do axr(A_STATUS, d, r); while (d[0] !== 1'b0);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge aclk);
		fails++;
		give_verdict();
	end
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		logic nak;
		logic [7:0] x, e;
		int o;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, awprot, arprot} = '0;
		wstrb = 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		axr(A_STATUS, d, r);
		compare(32'(d[23:16]), 32'(STS_NOT_EXEC));
		axr(12'h800, d, r);
		compare(d, 32'h0000_0000);
		compare(32'(r), 32'(RESP_SLVERR));
		axw(12'h800, 32'h1, r);
		compare(32'(r), 32'(RESP_SLVERR));
		for (int i = 0; i < STATIC_BYTES; i++) begin
			axw(A_STATIC + 12'(4 * i), 32'h40 + 32'(i), r);
			compare(32'(r), 32'(RESP_OKAY));
		end
		axw(A_STRETCH, 32'd100, r);
		axr(A_STRETCH, d, r);
		// the register keeps what was written; the cap acts only on the line
		compare(d, 32'd100);
		axw(A_PREP, 32'd4, r);
		$display("register test done");
		o = 0;
		for (int c = 1; c <= 12; c++) begin
			host.send_cmd(8'(c), {DEV, 1'b0} ^ 8'(c), nak);
			wait_ready();
			host.get_reply(lens[c] + 2, nak);
			compare(32'(host.rx[0]), 32'(STS_OK));
			x = {DEV, 1'b1} ^ STS_OK;
			for (int k = 0; k < lens[c]; k++) begin
				e = 8'h40 + 8'(o + k);
				if (o + k == 48)
					e &= 8'h1F;
				x ^= e;
				compare(32'(host.rx[k + 1]), 32'(e));
			end
			compare(32'(host.rx[lens[c] + 1]), 32'(x));
			o += lens[c];
		end
		$display("query test done");
		// a wrong check byte on purpose: unknown codes must not look at it
		for (int c = 13; c <= 18; c++) begin
			host.send_cmd(c == 18 ? CMD_CLASS : 8'(c % 17), 8'h00, nak);
			wait_ready();
			host.get_reply(3, nak);
			e = c == 18 ? STS_CHECK_ERR : STS_UNKNOWN;
			compare(32'(host.rx[0]), 32'(e));
			compare(32'({host.rx[1], host.rx[2]}), 32'({{DEV, 1'b1} ^ e, 8'hFF}));
		end
		$display("unknown test done");
		axw(A_CTRL, 32'h1, r);
		host.send_cmd(CMD_CLASS, {DEV, 1'b0} ^ CMD_CLASS, nak);
		compare(32'(nak), 32'(1'b1));
		host.get_reply(2, nak);
		compare(32'(nak), 32'(1'b1));
		axw(A_CTRL, 32'h0, r);
		axw(A_PREP, 32'd3000, r);
		host.send_cmd(CMD_REACH, {DEV, 1'b0} ^ CMD_REACH, nak);
		compare(32'(nak), 32'(1'b0));
		host.get_reply(3, nak);
		compare(32'(nak), 32'(1'b1));
		host.get_reply(3, nak);
		compare(32'({nak, host.rx[0], host.rx[1]}), 32'({1'b0, STS_OK, 8'h44}));
		$display("busy test done");
		give_verdict();
	end
endmodule
